// File: rtl/hsct_map.svh
// Named constants for the compensation and trim datapath.
// Assumes inclusion by bare name; the macros need nothing from hsct_pkg.
// Function
// - Coarse gain is a 3-bit code giving 1 to 32 times.
// - Fine gain is an 11-bit code giving 0.5 to 1.5, after coarse.
// - Coarse and fine together span 0.5 to 48 times.
// - A signed 16-bit quiescent offset is added to the scaled signal.
// - Output never goes below the 12-bit floor limit unless the floor is above the ceiling.
// - Output never goes above the 12-bit ceiling limit unless the floor is above the ceiling.
// - Warm and cool 11-bit first order gain temperature coefficients.
// - Warm and cool 10-bit second order gain temperature coefficients.
// - Warm and cool 12-bit offset drift coefficients, 1/64 (warm) and 1/32 (cool) LSB per degree.
// - After the curve, a signed 12-bit gain trim of range plus or minus one.
// - After the curve, a signed 12-bit offset trim is added.
// - One bit inverts the curve stage output.
// - One bit inverts the curve stage input.
// - Warm coefficients from 25 degrees up, cool ones below.
// - Sample is multiplied by a temperature gain from the region's coefficients.
// - The sample is signed two's complement up to the output clamps, which give an unsigned 12-bit code.
// - The gain stage result is held as a 17-bit signed value.
// - Offset stage adds offset plus drift times delta, giving 13-bit signed.
// - Temperature delta is ambient temperature minus 25 degrees.
`ifndef HSCT_MAP_SVH
`define HSCT_MAP_SVH

`define HSCT_TEMP_REF      10'sh019
`define HSCT_CRS_SH_MAX    3'h5
`define HSCT_FINE_BASE     12'h400
`define HSCT_FINE_UNITY    11'h400
`define HSCT_FINE_FRAC     11
`define HSCT_GAIN_ONE      40'sh0002000000
`define HSCT_GAIN_FRAC     25
`define HSCT_TC1_WARM_SH   7
`define HSCT_TC1_COOL_SH   8
`define HSCT_TC2_COOL_SH   2
`define HSCT_QOTC_WARM_SH  6
`define HSCT_QOTC_COOL_SH  5
`define HSCT_Y1_MAX        17'sh0ffff
`define HSCT_Y1_MIN        17'sh10000
`define HSCT_Y2_MAX        13'sh0fff
`define HSCT_Y2_MIN        13'sh1000
`define HSCT_BP_COUNT      5'h11
`define HSCT_BP_LAST       5'h10
`define HSCT_LIN_Y0        14'sh3800
`define HSCT_LIN_YN        14'sh0800
`define HSCT_LIN_MIN       14'sh3700
`define HSCT_LIN_MAX       14'sh0900
`define HSCT_LIN_STEP_SH   8
`define HSCT_PG_FRAC       11
`define HSCT_OUT_MID       17'sh00800

`endif

// File: rtl/hsct_pkg.sv
// Types shared by the compensation and trim datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package hsct_pkg;
    typedef logic signed [15:0] hsct_sample_t;
    typedef logic signed [9:0]  hsct_temp_t;
    typedef logic        [11:0] hsct_code_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SCALE, ST_TEMP, ST_OFFS, ST_SCAN, ST_INTERP, ST_POST, ST_PUSH
    } hsct_state_t;
endpackage : hsct_pkg

// File: rtl/hsct_fifo.sv
// Result FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/100ps

module hsct_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;

    // Extra pointer bit tells full from empty without a counter
    wire push_w = in_valid && in_ready;
    wire pop_w  = out_valid && out_ready;
    assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push_w) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop_w) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push_w) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
endmodule : hsct_fifo

// File: rtl/hsct_bp_mem.sv
// Breakpoint table: 17 words of 12 bits, one write port, registered read.
// Assumes writes come from the configuration loader in the same clock.
`timescale 1ns/100ps
`include "hsct_map.svh"

module hsct_bp_mem (
    input  wire logic        ref_clk,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [11:0] wr_data,
    input  wire logic [4:0]  rd_addr,
    output logic [11:0]      rd_data
);
    logic [11:0] mem_reg [17];

    // Writes past the last entry are dropped
    always_ff @(posedge ref_clk) begin
        if (wr_en && wr_addr <= `HSCT_BP_LAST) mem_reg[wr_addr] <= wr_data;
        rd_data <= (rd_addr <= `HSCT_BP_LAST) ? mem_reg[rd_addr] : '0;
    end
endmodule : hsct_bp_mem

// File: rtl/hsct_trim.sv
// Compensation and trim datapath: gain, temperature, offset, curve, post trim, clamps.
// Assumes configuration ports hold still while a sample is in flight.
`timescale 1ns/100ps
`include "hsct_map.svh"

module hsct_trim (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire hsct_pkg::hsct_sample_t sample_data,
    input  wire hsct_pkg::hsct_temp_t   temp_c,
    input  wire logic                   sample_valid,
    output logic                        sample_ready,
    input  wire logic                   gain_polarity,
    input  wire logic [2:0]             gain_coarse,
    input  wire logic [10:0]            gain_fine,
    input  wire logic signed [10:0]     gain_tc1_warm,
    input  wire logic signed [10:0]     gain_tc1_cool,
    input  wire logic signed [9:0]      gain_tc2_warm,
    input  wire logic signed [9:0]      gain_tc2_cool,
    input  wire logic signed [15:0]     quiescent_offset_trim,
    input  wire logic signed [11:0]     offset_drift_warm,
    input  wire logic signed [11:0]     offset_drift_cool,
    input  wire logic                   curve_in_invert,
    input  wire logic                   curve_out_invert,
    input  wire logic signed [11:0]     post_curve_gain,
    input  wire logic signed [11:0]     post_curve_offset,
    input  wire logic [11:0]            output_floor_limit,
    input  wire logic [11:0]            output_ceiling_limit,
    input  wire logic                   curve_breakpoint_wr_en,
    input  wire logic [4:0]             curve_breakpoint_wr_addr,
    input  wire logic [11:0]            curve_breakpoint_wr_data,
    output hsct_pkg::hsct_code_t        out_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic                        clamp_active
);
    import hsct_pkg::*;

    hsct_state_t        state_reg;
    hsct_state_t        state_next;
    hsct_sample_t       samp_reg;
    logic signed [9:0]  dt_reg;
    logic               warm_reg;
    logic signed [39:0] gain_reg;
    logic signed [23:0] a_reg;
    logic signed [16:0] y1_reg;
    logic signed [12:0] y2_reg;
    logic signed [13:0] v_reg;
    logic signed [13:0] y3_reg;
    logic signed [16:0] y4_reg;
    logic [4:0]         idx_reg;
    logic [4:0]         cnt_reg;
    logic               hi_seen_reg;
    logic signed [11:0] xlo_reg;
    logic signed [11:0] xhi_reg;
    logic signed [11:0] x0_reg;
    logic signed [11:0] x1_reg;
    logic signed [11:0] x15_reg;
    logic signed [11:0] x16_reg;
    logic               sample_ready_reg;
    logic               out_valid_reg;
    logic               clamp_reg;
    hsct_code_t         out_data_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Temperature region and gain factor
    wire               accept_w = sample_valid && sample_ready_reg;
    wire signed [9:0]  dt_w     = temp_c - `HSCT_TEMP_REF;
    wire               warm_w   = temp_c >= `HSCT_TEMP_REF;
    wire signed [10:0] tc1_w    = warm_w ? gain_tc1_warm : gain_tc1_cool;
    wire signed [9:0]  tc2_w    = warm_w ? gain_tc2_warm : gain_tc2_cool;
    wire signed [39:0] t1_w     = tc1_w * dt_w;
    wire signed [39:0] t2_w     = tc2_w * dt_w * dt_w;
    // Cool steps are twice and four times the warm ones, so shift into one Q25 scale
    wire signed [39:0] tc_sum_w = warm_w ? (t1_w <<< `HSCT_TC1_WARM_SH) + t2_w
                                         : (t1_w <<< `HSCT_TC1_COOL_SH) + (t2_w <<< `HSCT_TC2_COOL_SH);
    wire signed [39:0] gain_w   = `HSCT_GAIN_ONE + tc_sum_w;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Coarse, fine and polarity scaling of the signed sample
    wire [2:0]         crs_sh_w = (gain_coarse > `HSCT_CRS_SH_MAX) ? `HSCT_CRS_SH_MAX : gain_coarse;
    wire signed [23:0] crs_w    = samp_reg <<< crs_sh_w;
    wire [11:0]        fine_w   = `HSCT_FINE_BASE + {1'b0, gain_fine};
    wire signed [36:0] fprod_w  = crs_w * $signed({1'b0, fine_w});
    wire signed [36:0] fsh_w    = fprod_w >>> `HSCT_FINE_FRAC;
    wire signed [23:0] scaled_w = fsh_w[23:0];
    wire signed [23:0] a_next   = gain_polarity ? -scaled_w : scaled_w;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Gain stage result, saturated rather than wrapped
    wire signed [63:0] yprod_w = a_reg * gain_reg;
    wire signed [63:0] ysh_w   = yprod_w >>> `HSCT_GAIN_FRAC;
    wire signed [16:0] y1_next = (ysh_w > `HSCT_Y1_MAX) ? `HSCT_Y1_MAX :
                                 (ysh_w < `HSCT_Y1_MIN) ? `HSCT_Y1_MIN : ysh_w[16:0];

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Offset and drift
    wire signed [11:0] qotc_w   = warm_reg ? offset_drift_warm : offset_drift_cool;
    wire signed [21:0] drift_w  = qotc_w * dt_reg;
    wire signed [21:0] dsh_w    = drift_w >>> (warm_reg ? `HSCT_QOTC_WARM_SH : `HSCT_QOTC_COOL_SH);
    wire signed [21:0] y2_sum_w = y1_reg + quiescent_offset_trim + dsh_w;
    wire signed [12:0] y2_next  = (y2_sum_w > `HSCT_Y2_MAX) ? `HSCT_Y2_MAX :
                                  (y2_sum_w < `HSCT_Y2_MIN) ? `HSCT_Y2_MIN : y2_sum_w[12:0];
    // One bit wider so that inverting the most negative value cannot wrap
    wire signed [13:0] v_next   = curve_in_invert ? -y2_next : y2_next;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Breakpoint scan: one entry per cycle, entries assumed non-decreasing
    wire [11:0]        bp_rd_w;
    wire signed [11:0] bp_x_w    = bp_rd_w;
    wire [4:0]         bp_addr_w = (state_reg == ST_SCAN) ? idx_reg + 5'h01 : 5'h00;
    wire               bp_le_w   = bp_x_w <= v_reg;

    hsct_bp_mem u_bp_mem (
        .ref_clk (ref_clk),
        .wr_en   (curve_breakpoint_wr_en),
        .wr_addr (curve_breakpoint_wr_addr),
        .wr_data (curve_breakpoint_wr_data),
        .rd_addr (bp_addr_w),
        .rd_data (bp_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Interpolation; end segments extrapolate from the two outer points
    wire               at_lo_w  = cnt_reg == 5'h00;
    wire               at_hi_w  = cnt_reg == `HSCT_BP_COUNT;
    wire [4:0]         seg_w    = cnt_reg - 5'h01;
    wire signed [13:0] mid_b_w  = `HSCT_LIN_Y0 + ($signed({10'h000, seg_w[3:0]}) <<< `HSCT_LIN_STEP_SH);
    wire signed [13:0] base_w   = at_lo_w ? `HSCT_LIN_Y0 : at_hi_w ? `HSCT_LIN_YN : mid_b_w;
    wire signed [13:0] num_w    = at_lo_w ? x0_reg - v_reg : at_hi_w ? v_reg - x16_reg : v_reg - xlo_reg;
    wire signed [13:0] den_w    = at_lo_w ? x1_reg - x0_reg : at_hi_w ? x16_reg - x15_reg : xhi_reg - xlo_reg;
    wire [23:0]        nsh_w    = {10'h000, num_w} << `HSCT_LIN_STEP_SH;
    // A flat end segment has no slope; the endpoint value is used
    wire [23:0]        quot_w   = (den_w > 14'sh0000) ? nsh_w / {10'h000, den_w} : 24'h000000;
    wire signed [25:0] q_w      = $signed({2'b00, quot_w});
    wire signed [25:0] lin_r_w  = at_lo_w ? base_w - q_w : base_w + q_w;
    wire signed [13:0] lin_w    = (lin_r_w < `HSCT_LIN_MIN) ? `HSCT_LIN_MIN :
                                  (lin_r_w > `HSCT_LIN_MAX) ? `HSCT_LIN_MAX : lin_r_w[13:0];
    wire signed [13:0] y3_next  = curve_out_invert ? -lin_w : lin_w;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Post trim and clamps; floor wins if the limits cross
    wire signed [25:0] pg_w     = y3_reg * post_curve_gain;
    wire signed [25:0] pgs_w    = pg_w >>> `HSCT_PG_FRAC;
    // Part-select is unsigned; recast so a negative offset is sign-extended
    wire signed [16:0] y4_next  = $signed(pgs_w[16:0]) + post_curve_offset + `HSCT_OUT_MID;
    wire               lo_hit_w = y4_reg < $signed({5'h00, output_floor_limit});
    wire               hi_hit_w = y4_reg > $signed({5'h00, output_ceiling_limit});
    wire [11:0]        code_w   = lo_hit_w ? output_floor_limit : hi_hit_w ? output_ceiling_limit : y4_reg[11:0];

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Result FIFO and registered output stage
    wire        fifo_in_ready_w;
    wire        fifo_out_valid_w;
    wire [11:0] fifo_out_data_w;
    wire        push_w = (state_reg == ST_PUSH) && fifo_in_ready_w;
    wire        pop_w  = fifo_out_valid_w && (!out_valid_reg || out_ready);

    hsct_fifo #(
        .WIDTH (12),
        .DEPTH (16)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (state_reg == ST_PUSH),
        .in_ready  (fifo_in_ready_w),
        .in_data   (code_w),
        .out_valid (fifo_out_valid_w),
        .out_ready (pop_w),
        .out_data  (fifo_out_data_w)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer; a full FIFO holds the result and stops new samples
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (accept_w) state_next = ST_SCALE;
            ST_SCALE:  state_next = ST_TEMP;
            ST_TEMP:   state_next = ST_OFFS;
            ST_OFFS:   state_next = ST_SCAN;
            ST_SCAN:   if (idx_reg == `HSCT_BP_LAST) state_next = ST_INTERP;
            ST_INTERP: state_next = ST_POST;
            ST_POST:   state_next = ST_PUSH;
            ST_PUSH:   if (fifo_in_ready_w) state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg        <= ST_IDLE;
            sample_ready_reg <= 1'b0;
        end else begin
            state_reg        <= state_next;
            sample_ready_reg <= state_next == ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            samp_reg <= '0;
            dt_reg   <= '0;
            warm_reg <= 1'b0;
            gain_reg <= '0;
        end else if (accept_w) begin
            samp_reg <= sample_data;
            dt_reg   <= dt_w;
            warm_reg <= warm_w;
            gain_reg <= gain_w;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            a_reg  <= '0;
            y1_reg <= '0;
            y2_reg <= '0;
            v_reg  <= '0;
            y3_reg <= '0;
            y4_reg <= '0;
        end else begin
            if (state_reg == ST_SCALE) a_reg <= a_next;
            if (state_reg == ST_TEMP) y1_reg <= y1_next;
            if (state_reg == ST_OFFS) y2_reg <= y2_next;
            if (state_reg == ST_OFFS) v_reg <= v_next;
            if (state_reg == ST_INTERP) y3_reg <= y3_next;
            if (state_reg == ST_POST) y4_reg <= y4_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_reg     <= '0;
            cnt_reg     <= '0;
            hi_seen_reg <= 1'b0;
            xlo_reg     <= '0;
            xhi_reg     <= '0;
        end else if (state_reg == ST_OFFS) begin
            idx_reg     <= '0;
            cnt_reg     <= '0;
            hi_seen_reg <= 1'b0;
        end else if (state_reg == ST_SCAN) begin
            idx_reg <= idx_reg + 5'h01;
            if (bp_le_w) begin
                cnt_reg <= idx_reg + 5'h01;
                xlo_reg <= bp_x_w;
            end else if (!hi_seen_reg) begin
                xhi_reg     <= bp_x_w;
                hi_seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            x0_reg  <= '0;
            x1_reg  <= '0;
            x15_reg <= '0;
            x16_reg <= '0;
        end else if (state_reg == ST_SCAN) begin
            if (idx_reg == 5'h00) x0_reg <= bp_x_w;
            if (idx_reg == 5'h01) x1_reg <= bp_x_w;
            if (idx_reg == `HSCT_BP_LAST - 5'h01) x15_reg <= bp_x_w;
            if (idx_reg == `HSCT_BP_LAST) x16_reg <= bp_x_w;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
            clamp_reg     <= 1'b0;
        end else begin
            if (pop_w) out_valid_reg <= 1'b1;
            else if (out_ready) out_valid_reg <= 1'b0;
            if (pop_w) out_data_reg <= fifo_out_data_w;
            if (push_w) clamp_reg <= lo_hit_w || hi_hit_w;
        end
    end

    assign sample_ready = sample_ready_reg;
    assign out_valid    = out_valid_reg;
    assign out_data     = out_data_reg;
    assign clamp_active = clamp_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_region_select: assert property (accept_w |=> warm_reg == ($past(temp_c) >= `HSCT_TEMP_REF))
        else $error("region select wrong");
    chk_temp_delta: assert property (accept_w |=> dt_reg == $past(temp_c) - `HSCT_TEMP_REF)
        else $error("temperature delta wrong");
    chk_unity_scale: assert property ((state_reg == ST_SCALE && gain_coarse == 3'h0 && gain_fine == `HSCT_FINE_UNITY)
        |=> a_reg == (gain_polarity ? -$past(samp_reg) : $past(samp_reg)))
        else $error("unity scale or polarity wrong");
    chk_unity_gain: assert property ((state_reg == ST_TEMP && gain_reg == `HSCT_GAIN_ONE
        && a_reg <= 24'sh00ffff && a_reg >= -24'sh010000) |=> y1_reg == $past(a_reg))
        else $error("unity temperature gain wrong");
    chk_in_invert: assert property (state_reg == ST_OFFS
        |=> v_reg == ($past(curve_in_invert) ? -y2_reg : y2_reg))
        else $error("curve input inversion wrong");
    chk_scan_step: assert property ((state_reg == ST_SCAN && idx_reg != `HSCT_BP_LAST)
        |=> state_reg == ST_SCAN && idx_reg == $past(idx_reg) + 5'h01)
        else $error("breakpoint scan skipped an entry");
    chk_scan_end: assert property (state_reg == ST_OFFS |=> ##17 state_reg == ST_INTERP)
        else $error("breakpoint scan length wrong");
    chk_offset_only: assert property ((state_reg == ST_POST && post_curve_gain == 12'sh000)
        |=> y4_reg == $past(post_curve_offset) + `HSCT_OUT_MID)
        else $error("post offset wrong");
    chk_floor_limit: assert property ((push_w && output_floor_limit <= output_ceiling_limit)
        |-> code_w >= output_floor_limit)
        else $error("output below floor");
    chk_ceiling_limit: assert property ((push_w && output_floor_limit <= output_ceiling_limit)
        |-> code_w <= output_ceiling_limit)
        else $error("output above ceiling");

    cov_result_out: cover property (push_w ##[1:40] out_valid_reg && out_ready);
    cov_cool_region: cover property (accept_w && !warm_w);
    cov_clamped: cover property (push_w && (lo_hit_w || hi_hit_w));
    cov_extrapolate: cover property (state_reg == ST_INTERP && (at_lo_w || at_hi_w));
endmodule : hsct_trim

// File: tb/hsct_trim_test.sv
// Self-checking bench for the compensation and trim datapath.
// Assumes rtl/ compiled first; curve table set so the curve stage doubles its input.
`timescale 1ns/100ps
module hsct_trim_test;
import hsct_pkg::*;
////////////////////////////////////////////////////////////
logic ref_clk = 0, rst_b = 0, sv = 0, ordy = 1, pol = 0, cin = 0, cout = 0, we = 0;
hsct_sample_t sd = '0;
hsct_temp_t tc = '0;
logic [2:0] crs = '0;
logic [10:0] fn = '0;
logic [4:0] wa = '0;
logic [11:0] wd = '0, flo = '0, cei = 12'hfff;
logic signed [10:0] t1w = '0, t1c = '0;
logic signed [9:0] t2w = '0, t2c = '0;
logic signed [15:0] qo = '0;
logic signed [11:0] dw = '0, dc = '0, pg = 12'sh400, po = '0;
logic srdy, ovld, clmp;
hsct_code_t od;
int err_total = 0, comparisons = 0, cyc = 0;
logic [31:0] rs = 32'd1507, r;
logic [12:0] q[$], e;
bit strm = 1;
hsct_trim u_hsct_trim (.ref_clk(ref_clk), .rst_b(rst_b), .sample_data(sd), .temp_c(tc), .sample_valid(sv),
    .sample_ready(srdy), .gain_polarity(pol), .gain_coarse(crs), .gain_fine(fn), .gain_tc1_warm(t1w),
    .gain_tc1_cool(t1c), .gain_tc2_warm(t2w), .gain_tc2_cool(t2c), .quiescent_offset_trim(qo),
    .offset_drift_warm(dw), .offset_drift_cool(dc), .curve_in_invert(cin), .curve_out_invert(cout),
    .post_curve_gain(pg), .post_curve_offset(po), .output_floor_limit(flo), .output_ceiling_limit(cei),
    .curve_breakpoint_wr_en(we), .curve_breakpoint_wr_addr(wa), .curve_breakpoint_wr_data(wd),
    .out_data(od), .out_valid(ovld), .out_ready(ordy), .clamp_active(clmp));
initial forever #20 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////
function automatic logic [31:0] rnd();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
endfunction : rnd
function automatic logic [12:0] model();
    longint dt, g, a, y, w;
    bit hot;
    dt = tc - 25;
    hot = (tc >= 25);
    g = (64'sd1 <<< 25) + ((longint'(hot ? t1w : t1c) * dt) <<< (hot ? 7 : 8))
        + ((longint'(hot ? t2w : t2c) * dt * dt) <<< (hot ? 0 : 2));
    a = ((longint'(sd) <<< (crs > 5 ? 5 : crs)) * (1024 + longint'(fn))) >>> 11;
    if (pol) a = -a;
    y = (a * g) >>> 25;
    y = y > 65535 ? 65535 : y < -65536 ? -65536 : y;
    y = y + qo + ((longint'(hot ? dw : dc) * dt) >>> (hot ? 6 : 5));
    y = y > 4095 ? 4095 : y < -4096 ? -4096 : y;
    if (cin) y = -y;
    y = 2 * y;
    y = y > 2304 ? 2304 : y < -2304 ? -2304 : y;
    if (cout) y = -y;
    w = ((y * pg) >>> 11) + po + 2048;
    if (w < longint'(flo)) return {1'b1, flo};
    if (w > longint'(cei)) return {1'b1, cei};
    return {1'b0, w[11:0]};
endfunction : model
task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
        err_total++;
        $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
endtask : chk
task automatic finish_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask : finish_test
// Config only changes while the sequencer is idle, so the model sees what the design reads
task automatic randcfg(input int i);
    r = rnd();
    crs <= i == 0 || i == 5 ? 3'h0 : r[2:0]; fn <= i == 0 || i == 5 ? 11'h400 : r[13:3];
    pol <= r[14]; cin <= r[15]; cout <= r[16];
    qo <= {{6{r[26]}}, r[26:17]}; sd <= i == 2 ? 16'sh7fff : i == 3 ? 16'sh8000 : r[31] ? rs[15:0] : {{7{r[27]}}, r[27:19]};
    r = rnd();
    t1w <= r[10:0]; t2w <= r[20:11]; dw <= r[31:20];
    r = rnd();
    t1c <= r[10:0]; t2c <= r[20:11]; dc <= r[31:20];
    tc <= i == 0 ? 10'sd25 : i == 1 ? 10'sd24 : i == 4 ? -10'sd40 : 10'(r[7:0]) - 10'sd60;
    r = rnd();
    pg <= i == 6 ? 12'sh000 : r[11:0]; po <= r[23:12]; flo <= {1'b0, r[10:0]}; cei <= {1'b1, r[31:21]};
endtask : randcfg
// Waits for an idle sequencer, then changes config and offers one sample on the next edge
task automatic send(input int i, input int lim, output bit ok);
    int n;
    n = 0;
    do begin
        @(posedge ref_clk); n++;
    end while (srdy !== 1'b1 && n < lim);
    ok = (srdy === 1'b1);
    if (ok) begin
        randcfg(i); sv <= 1;
        @(posedge ref_clk);
        sv <= 0; q.push_back(model());
    end
endtask : send
////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
        err_total++; finish_test();
    end
    if (rst_b && ovld === 1'b1 && ordy) begin
        e = q.pop_front();
        chk("out_data", od, e[11:0]);
        if (strm) chk("clamp_active", clmp, e[12]);
    end
end
initial begin
    bit ok;
    int k, i;
    repeat (10) @(posedge ref_clk);
    chk("reset", {srdy, ovld, clmp, od}, 0);
    rst_b <= 1;
    // Two stray writes above the table must be ignored
    for (k = 0; k < 19; k++) begin
        @(posedge ref_clk); we <= 1; wa <= 5'(k); wd <= k < 17 ? 12'(-1024 + 128 * k) : 12'h7ff;
    end
    @(posedge ref_clk); we <= 0;
    for (i = 0; i < 300; i++) begin
        send(i, 100, ok);
        chk("accept", ok, 1);
    end
    repeat (40) @(posedge ref_clk);
    strm = 0; ordy <= 0; k = 0; ok = 1;
    while (ok && k < 40) begin
        send(9, 80, ok); k += ok;
    end
    chk("fill", k >= 16, 1);
    chk("stall", srdy, 0);
    ordy <= 1; send(9, 800, ok);
    chk("resume", ok, 1);
    repeat (60) @(posedge ref_clk);
    chk("drained", q.size(), 0);
    finish_test();
end
endmodule : hsct_trim_test
